// *** core/dsp_port.v ***
`timescale 1ns/1ps
`default_nettype none
`include "dsp_defs.vh"
module dsp_port (
   input  wire        clock,
   input  wire        rst,
   input  wire        cs_n,
   input  wire        sck,
   input  wire        serial_in,
   output reg         serial_out,
   output reg         serial_out_en,
   output wire        conv_start,
   output wire        temp_sensor_select,
   output wire        reject_sel_a,
   output wire        reject_sel_b,
   output wire        double_rate_select,
   output wire        calib_pass_second,
   input  wire        conv_done,
   input  wire        conv_sign,
   input  wire        conv_over,
   input  wire        conv_under,
   input  wire [28:0] conv_code,
   output wire        result_ready,
   output reg         converting,
   output reg         sleeping
);
   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   reg  [1:0] cs_sync;
   reg  [1:0] sck_sync;
   reg  [1:0] sdi_sync;
   reg        cs_q;
   reg        sck_q;
   wire       cs_low;
   wire       sck_rise;
   wire       sck_fall;
   wire       cs_rise;

   always @(posedge clock) begin
      if (rst) begin
         cs_sync  <= 2'b11;
         sck_sync <= 2'b00;
         sdi_sync <= 2'b00;
         cs_q     <= 1'b1;
         sck_q    <= 1'b0;
      end else begin
         cs_sync  <= {cs_sync[0], cs_n};
         sck_sync <= {sck_sync[0], sck};
         sdi_sync <= {sdi_sync[0], serial_in};
         cs_q     <= cs_sync[1];
         sck_q    <= sck_sync[1];
      end
   end

   assign cs_low   = ~cs_sync[1];
   assign cs_rise  = cs_sync[1] & ~cs_q;
   // Serial clock edges only count while selected; when deselected they are dropped.
   assign sck_rise = cs_low & sck_sync[1] & ~sck_q;
   assign sck_fall = cs_low & ~sck_sync[1] & sck_q;

   // ---------------------------------------------------------------
   // State machine
   // ---------------------------------------------------------------
   localparam [2:0] ST_CONV  = 3'b001;
   localparam [2:0] ST_SLEEP = 3'b010;
   localparam [2:0] ST_OUT   = 3'b100;

   reg  [2:0] state;
   reg  [2:0] next_state;
   reg  [5:0] rise_cnt;
   reg  [5:0] fall_cnt;
   reg  [31:0] shift;
   reg  [7:0] cfg_shift;
   reg        temp_mode;
   reg  [1:0] rej_mode;
   reg        speed_mode;
   reg        start_pulse;
   reg        pass_second;
   wire       out_done;
   wire       fifo_valid;
   wire [30:0] fifo_data;
   wire       fifo_take;
   wire [30:0] packed_result;
   wire [7:0] cfg_word;

   assign out_done = sck_fall && (fall_cnt == 6'd31);

   always @* begin
      next_state = state;
      case (state)
         ST_CONV: begin
            if (fifo_valid) begin
               next_state = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (cs_low && sck_rise) begin
               next_state = ST_OUT;
            end
         end
         ST_OUT: begin
            if (cs_rise || out_done) begin
               next_state = ST_CONV;
            end
         end
         default: begin
            next_state = ST_CONV;
         end
      endcase
   end

   assign fifo_take = (state == ST_CONV) && fifo_valid;

   // ---------------------------------------------------------------
   // Configuration and output shifting
   // ---------------------------------------------------------------
   // The word shifts in first-bit-first, so the first bit lands in bit 7.
   assign cfg_word = {cfg_shift[6:0], sdi_sync[1]};

   always @(posedge clock) begin
      if (rst) begin
         state       <= ST_CONV;
         rise_cnt    <= 6'd0;
         fall_cnt    <= 6'd0;
         shift       <= 32'h0000_0000;
         cfg_shift   <= 8'h00;
         temp_mode   <= 1'b0;
         rej_mode    <= `DSP_REJ_BOTH;
         speed_mode  <= 1'b0;
         start_pulse <= 1'b1;
         pass_second <= 1'b0;
      end else begin
         state       <= next_state;
         start_pulse <= 1'b0;
         if (fifo_take) begin
            // Bit 31 is low: the word is only captured once the conversion is done.
            shift <= {1'b0, fifo_data};
         end
         if (state == ST_SLEEP) begin
            rise_cnt  <= 6'd0;
            fall_cnt  <= 6'd0;
            cfg_shift <= 8'h00;
         end
         if (next_state == ST_OUT || state == ST_OUT) begin
            if (sck_rise) begin
               rise_cnt <= rise_cnt + 6'd1;
               if (rise_cnt < 6'd8) begin
                  cfg_shift <= cfg_word;
               end
               // The eighth bit completes the word; apply only with enable set.
               if (rise_cnt == 6'd7 && cfg_word[7-`DSP_CFG_ENABLE]) begin
                  temp_mode  <= cfg_word[7-`DSP_CFG_TEMP];
                  rej_mode   <= {cfg_word[7-`DSP_CFG_REJ_A], cfg_word[7-`DSP_CFG_REJ_B]};
                  speed_mode <= cfg_word[7-`DSP_CFG_SPEED];
               end
            end
            if (sck_fall) begin
               fall_cnt <= fall_cnt + 6'd1;
               shift    <= {shift[30:0], 1'b1};
            end
         end
         if (state == ST_OUT && next_state == ST_CONV) begin
            start_pulse <= 1'b1;
            pass_second <= 1'b0;
         end else if (state == ST_CONV && conv_done && !fifo_valid && !double_rate_select) begin
            pass_second <= ~pass_second;
         end
      end
   end

   // ---------------------------------------------------------------
   // Serial output pin
   // ---------------------------------------------------------------
   always @(posedge clock) begin
      if (rst) begin
         serial_out    <= 1'b1;
         serial_out_en <= 1'b0;
         converting    <= 1'b1;
         sleeping      <= 1'b0;
      end else begin
         serial_out_en <= cs_low;
         converting    <= (next_state == ST_CONV);
         sleeping      <= (next_state == ST_SLEEP);
         if (next_state == ST_OUT) begin
            serial_out <= shift[31];
            if (sck_fall) begin
               // After the 32nd falling edge the return to conversion makes the line high.
               serial_out <= shift[30];
            end
         end else begin
            serial_out <= (next_state == ST_CONV);
         end
      end
   end

   // ---------------------------------------------------------------
   // Result packing
   // ---------------------------------------------------------------
   // Speed is forced to 1x while the temperature sensor is the input.
   assign double_rate_select = speed_mode & ~temp_mode;
   assign temp_sensor_select = temp_mode;
   assign reject_sel_a       = rej_mode[1];
   assign reject_sel_b       = rej_mode[0];
   assign conv_start         = start_pulse;
   assign calib_pass_second  = pass_second;

   // In 1x mode the first done marks only the first half of the offset pair.
   wire result_final = conv_done && (double_rate_select || pass_second);

   assign packed_result = conv_over  ? {1'b0, `DSP_OVER_SIGN, `DSP_OVER_CODE} :
                          conv_under ? {1'b0, `DSP_UNDER_SIGN,
                                        (double_rate_select ? `DSP_UNDER2X_CODE
                                                            : `DSP_UNDER_CODE)} :
                          {1'b0, conv_sign, conv_code};

   // The buffer is written only in ST_CONV, where it is read at once, so it never fills and result_ready stays high.
   dsp_fifo #(
      .WIDTH (`DSP_FIFO_WIDTH),
      .DEPTH (`DSP_FIFO_DEPTH),
      .AW    (`DSP_FIFO_AW)
   ) u_fifo (
      .clock     (clock),
      .rst       (rst),
      .in_data   (packed_result),
      .in_valid  (result_final && state == ST_CONV),
      .in_ready  (result_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_take)
   );
endmodule // dsp_port
`default_nettype wire

// *** core/dsp_defs.vh ***
`ifndef DSP_DEFS_VH
`define DSP_DEFS_VH
// Configuration word bit positions, counted from the first bit shifted in (0).
`define DSP_CFG_ENABLE      0
`define DSP_CFG_TEMP        4
`define DSP_CFG_REJ_A       5
`define DSP_CFG_REJ_B       6
`define DSP_CFG_SPEED       7
`define DSP_CFG_BITS        8
// Rejection mode codes {a,b}.
`define DSP_REJ_BOTH        2'b00
`define DSP_REJ_50          2'b01
`define DSP_REJ_60          2'b10
`define DSP_REJ_RESERVED    2'b11
// Output word.
`define DSP_WORD_BITS       32
`define DSP_RESULT_BITS     24
`define DSP_SUB_BITS        5
`define DSP_WORD_BITS_LOG   6
// Clamp codes placed in bits 28..0, with sign at bit 29.
`define DSP_OVER_SIGN       1'b1
`define DSP_OVER_CODE       29'h1000_0000
`define DSP_UNDER_SIGN      1'b0
`define DSP_UNDER_CODE      29'h0FFF_FFFF
`define DSP_UNDER2X_CODE    29'h0FFF_F000
// Result FIFO.
`define DSP_FIFO_WIDTH      31
`define DSP_FIFO_DEPTH      8
`define DSP_FIFO_AW         3
`endif

// *** core/dsp_fifo.v ***
`timescale 1ns/1ps
`default_nettype none
module dsp_fifo #(
   parameter WIDTH = 31,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   input  wire             clock,
   input  wire             rst,
   input  wire [WIDTH-1:0] in_data,
   input  wire             in_valid,
   output wire             in_ready,
   output reg  [WIDTH-1:0] out_data,
   output wire             out_valid,
   input  wire             out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr;
   reg [AW-1:0]    rd_ptr;
   reg [AW:0]      count;
   wire            do_wr;
   wire            do_rd;

   assign in_ready  = (count != DEPTH[AW:0]);
   assign out_valid = (count != {(AW+1){1'b0}});
   assign do_wr     = in_valid & in_ready;
   assign do_rd     = out_valid & out_ready;

   always @(posedge clock) begin
      if (do_wr) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always @* begin
      out_data = mem[rd_ptr];
   end

   always @(posedge clock) begin
      if (rst) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count  <= {(AW+1){1'b0}};
      end else begin
         if (do_wr) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (do_rd) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (do_wr && !do_rd) begin
            count <= count + 1'b1;
         end else if (do_rd && !do_wr) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule // dsp_fifo
`default_nettype wire

// *** verif/dsp_checker_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module dsp_checker (
   input wire logic clock,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic serial_out,
   input wire logic serial_out_en,
   input wire logic conv_start,
   input wire logic temp_sensor_select,
   input wire logic reject_sel_a,
   input wire logic reject_sel_b,
   input wire logic double_rate_select,
   input wire logic converting,
   input wire logic sleeping
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // Select passes two sync flops, so a few cycles of lag are allowed.
   AST_EN_OFF: assert property (cs_n [*5] |-> !serial_out_en)
      else $error("Output driven while select is high.");
   AST_MODE_HOLD: assert property (cs_n [*6] |=> $stable({temp_sensor_select,
      reject_sel_a, reject_sel_b, double_rate_select}))
      else $error("Mode changed while select is high.");
   AST_TEMP_1X: assert property (temp_sensor_select |-> !double_rate_select)
      else $error("Double rate with temperature input.");
   AST_START_PULSE: assert property (conv_start |=> !conv_start)
      else $error("Start pulse longer than one cycle.");
   AST_START_CONV: assert property (conv_start |-> ##[0:2] converting)
      else $error("Start without conversion.");
   AST_STATE_EXCL: assert property (converting |-> !sleeping)
      else $error("Converting and sleeping together.");
   AST_SLEEP_HOLD: assert property (cs_n [*6] ##0 sleeping |=> sleeping)
      else $error("Sleep left while select is high.");
   AST_EOC_LOW: assert property (sleeping && $past(sleeping) && serial_out_en
      && $past(serial_out_en) |-> !serial_out)
      else $error("Done flag not low in sleep.");
endmodule // dsp_checker
bind dsp_port dsp_checker u_chk (.clock(clock), .rst(rst), .cs_n(cs_n),
   .serial_out(serial_out), .serial_out_en(serial_out_en), .conv_start(conv_start),
   .temp_sensor_select(temp_sensor_select), .reject_sel_a(reject_sel_a),
   .reject_sel_b(reject_sel_b), .double_rate_select(double_rate_select),
   .converting(converting), .sleeping(sleeping));
`default_nettype wire

// *** verif/dsp_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Host model
// ------------------------------------------------------------
module dsp_host (
   input  wire logic clock,
   input  wire logic serial_out,
   input  wire logic serial_out_en,
   output var  logic cs_n,
   output var  logic sck,
   output var  logic serial_in
);
   logic last = 1'b0;
   // A released output shows the inverse of its last level, so a stale bit never matches.
   wire logic pin = serial_out_en ? serial_out : ~last;
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      serial_in = 1'b0;
   end
   always @(posedge clock) begin
      if (serial_out_en) begin
         last <= serial_out;
      end
   end
   // The link clock runs at 17 system clocks a period and stays low between frames.
   task automatic xfer(input logic [7:0] cfg, input int n, output logic [31:0] word,
                       output logic tail);
      word = 32'h0000_0000;
      @(posedge clock) cs_n <= 1'b0;
      repeat (8) @(posedge clock);
      for (int i = 0; i < n; i++) begin
         @(posedge clock) serial_in <= (i < 8) ? cfg[i] : 1'b0;
         repeat (8) @(posedge clock);
         word = {word[30:0], pin};
         sck <= 1'b1;
         repeat (8) @(posedge clock);
         sck <= 1'b0;
      end
      repeat (12) @(posedge clock);
      tail = pin;
      cs_n <= 1'b1;
      repeat (8) @(posedge clock);
   endtask
endmodule // dsp_host
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Testbench
// ------------------------------------------------------------
module tb_top;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        conv_done = 1'b0;
   logic        conv_sign = 1'b0;
   logic        conv_over = 1'b0;
   logic        conv_under = 1'b0;
   logic [28:0] conv_code = 29'h0000_0000;
   logic [31:0] word;
   logic        tail;
   int          bad_count = 0;
   int          comparisons = 0;
   wire logic   cs_n, sck, serial_in, serial_out, serial_out_en, conv_start, result_ready;
   wire logic   temp_sensor_select, reject_sel_a, reject_sel_b, double_rate_select;
   wire logic   calib_pass_second, converting, sleeping;
   // Data word: over, under, sign, code. No entry sets the reserved pair with enable.
   logic [7:0]  cfgs [5] = '{8'h00, 8'h4F, 8'hA1, 8'h91, 8'h0E};
   logic [3:0]  modes [5] = '{4'h0, 4'h2, 4'h5, 4'h8, 4'h8};
   logic [31:0] dat [5] = '{32'h2123_4567, 32'h8000_1234, 32'h1F00_0001, 32'h4000_0000,
                            32'h4000_0000};
   logic [31:0] expw [5] = '{32'h2123_4567, 32'h3000_0000, 32'h1F00_0001, 32'h0FFF_F000,
                             32'h0FFF_FFFF};
   always #2.5 clock = ~clock;
   dsp_port DUT (.clock(clock), .rst(rst), .cs_n(cs_n), .sck(sck), .serial_in(serial_in),
      .serial_out(serial_out), .serial_out_en(serial_out_en), .conv_start(conv_start),
      .temp_sensor_select(temp_sensor_select), .reject_sel_a(reject_sel_a),
      .reject_sel_b(reject_sel_b), .double_rate_select(double_rate_select),
      .calib_pass_second(calib_pass_second), .conv_done(conv_done), .conv_sign(conv_sign),
      .conv_over(conv_over), .conv_under(conv_under), .conv_code(conv_code),
      .result_ready(result_ready), .converting(converting), .sleeping(sleeping));
   dsp_host HOST (.clock(clock), .serial_out(serial_out), .serial_out_en(serial_out_en),
      .cs_n(cs_n), .sck(sck), .serial_in(serial_in));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("Counts: %0d mismatches, %0d comparisons", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic await(input logic want_sleep);
      int k;
      k = 0;
      while (((want_sleep ? sleeping : converting) !== 1'b1) && k < 400) begin
         @(posedge clock);
         k++;
      end
      if (k == 400) begin
         bad_count++;
         stop_test();
      end
   endtask
   // The converter side needs a second pass only while the calibrated mode asks for it.
   task automatic convert(input logic [31:0] d, input logic one_x);
      await(1'b0);
      for (int p = 0; p < 2; p++) begin
         @(posedge clock) conv_done <= 1'b1;
         {conv_over, conv_under, conv_sign, conv_code} <= d;
         @(posedge clock) conv_done <= 1'b0;
         repeat (4) @(posedge clock);
         if (p == 0) check(calib_pass_second, one_x);
         if (!one_x) break;
      end
      await(1'b1);
   endtask
   initial begin
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      repeat (2) @(posedge clock);
      check({temp_sensor_select, reject_sel_a, reject_sel_b, double_rate_select}, 0);
      check(serial_out_en, 1'b0);
      check(result_ready, 1'b1);
      for (int i = 0; i < 5; i++) begin
         convert(dat[i], i != 3);
         HOST.xfer(cfgs[i], 32, word, tail);
         check(word, expw[i]);
         check(tail, 1'b1);
         check({temp_sensor_select, reject_sel_a, reject_sel_b, double_rate_select},
               modes[i]);
      end
      convert(32'h2000_0005, 1'b1);
      HOST.xfer(8'h00, 10, word, tail);
      check(word, 32'h0000_0080);
      await(1'b0);
      check(converting, 1'b1);
      convert(32'h2000_0007, 1'b1);
      HOST.xfer(8'h00, 0, word, tail);
      check(tail, 1'b0);
      check(sleeping, 1'b1);
      HOST.xfer(8'h00, 32, word, tail);
      check(word, 32'h2000_0007);
      stop_test();
   end
endmodule // tb_top
`default_nettype wire
